// >>> tcc_dma_model.sv
// Behavioural DMA controller that acknowledges capture transfer requests.
`timescale 1ns/1ns
module tcc_dma_model (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       dma_req,
	input  wire logic [7:0] ack_delay,
	output logic            dma_ack,
	output int              n_req
);
	logic [7:0] wait_q;

	// A long delay keeps a request pending, so later captures must not raise a second one.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wait_q  <= 8'h00;
			dma_ack <= 1'b0;
			n_req   <= 0;
		end else begin
			dma_ack <= 1'b0;
			if (dma_req && !dma_ack) begin
				if (wait_q == ack_delay) begin
					dma_ack <= 1'b1;
					wait_q  <= 8'h00;
					n_req   <= n_req + 1;
				end else begin
					wait_q <= wait_q + 8'h01;
				end
			end
		end
	end
endmodule : tcc_dma_model

// >>> tcc_edge_if.sv
// Carrier for a synchronised pin level and its edge pulses.
`timescale 1ns/1ns
interface tcc_edge_if;
	logic level;
	logic rise;
	logic fall;
	modport src (output level, output rise, output fall);
	modport dst (input level, input rise, input fall);
endinterface : tcc_edge_if

// >>> tcc_pin_sync.sv
// Three-stage pin synchroniser with edge detection.
`timescale 1ns/1ns
module tcc_pin_sync (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic pin,
	tcc_edge_if.src   e
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
		logic rise;
		logic fall;
	} tcc_sync_s;

	tcc_sync_s q;
	tcc_sync_s n;

	// A change is accepted only when the second and third stages agree.
	always_comb begin
		n      = q;
		n.s1   = pin;
		n.s2   = q.s1;
		n.s3   = q.s2;
		n.rise = 1'b0;
		n.fall = 1'b0;
		if (q.s2 == q.s3 && q.s3 != q.level) begin
			n.level = q.s3;
			n.rise  = q.s3;
			n.fall  = ~q.s3;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign e.level = q.level;
	assign e.rise  = q.rise;
	assign e.fall  = q.fall;
endmodule : tcc_pin_sync

// >>> tcc_pkg.sv
// Shared constants for the five-channel timer control block.
package tcc_pkg;
	localparam int        CH_N        = 5;
	localparam logic [7:0] OFF_START   = 8'h00;
	localparam logic [7:0] OFF_OUTCTL  = 8'h04;
	localparam logic [7:0] OFF_CTL     = 8'h10;
	localparam logic [7:0] OFF_RELOAD  = 8'h30;
	localparam logic [7:0] OFF_COUNT   = 8'h50;
	localparam logic [7:0] OFF_CAPTURE = 8'h70;
	localparam int        B_CAPF      = 9;
	localparam int        B_UNF       = 8;
	localparam int        B_CAPHI     = 7;
	localparam int        B_CAPLO     = 6;
	localparam int        B_UNDERFLOW_IRQ_ENABLE      = 5;
	localparam int        B_EDGEHI    = 4;
	localparam int        B_EDGELO    = 3;
	localparam int        B_PSCHI     = 2;
	localparam logic [15:0] MASK_CH01 = 16'h013f;
	localparam logic [15:0] MASK_CH2  = 16'h03ff;
	localparam logic [15:0] MASK_CH34 = 16'h0127;
	localparam logic [15:0] CTL_RST    = 16'h0000;
	localparam logic [31:0] RELOAD_RST = 32'hffffffff;
	localparam logic [31:0] COUNT_RST  = 32'hffffffff;
	localparam logic [4:0]  START_RST  = 5'h00;
	localparam logic [2:0] PSC_DIV4    = 3'h0;
	localparam logic [2:0] PSC_DIV16   = 3'h1;
	localparam logic [2:0] PSC_DIV64   = 3'h2;
	localparam logic [2:0] PSC_DIV256  = 3'h3;
	localparam logic [2:0] PSC_DIV1024 = 3'h4;
	localparam logic [2:0] PSC_RTC     = 3'h6;
	localparam logic [2:0] PSC_EXT     = 3'h7;
	localparam logic [9:0] DMASK_4     = 10'h003;
	localparam logic [9:0] DMASK_16    = 10'h00f;
	localparam logic [9:0] DMASK_64    = 10'h03f;
	localparam logic [9:0] DMASK_256   = 10'h0ff;
	localparam logic [9:0] DMASK_1024  = 10'h3ff;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : tcc_pkg

// >>> tcc_timer.sv
// Five-channel down-counting timer with control, capture and AXI4-Lite access.
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
module tcc_timer
	import tcc_pkg::*;
#(
	parameter int CNT_W = 32
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [7:0]        awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [7:0]        araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	input  wire logic              ext_timer_clock_pin_i,
	output logic                   ext_timer_clock_pin_o,
	output logic                   ext_timer_clock_pin_oe,
	input  wire logic              rtc_clk_i,
	input  wire logic              module_standby,
	output logic                   dma_req,
	input  wire logic              dma_ack,
	output logic [CH_N-1:0]        underflow_irq,
	output logic                   capture_irq
);
	typedef struct packed {
		logic                        awready;
		logic                        wready;
		logic                        bvalid;
		logic [1:0]                  bresp;
		logic                        arready;
		logic                        rvalid;
		logic [1:0]                  rresp;
		logic [31:0]                 rdata;
		logic                        aw_have;
		logic                        w_have;
		logic [7:0]                  waddr;
		logic [31:0]                 wdat;
		logic [3:0]                  wstb;
		logic [CH_N-1:0]             start;
		logic                        pin_oe;
		logic [CH_N-1:0][15:0]       ctl;
		logic [CH_N-1:0][CNT_W-1:0]  reload;
		logic [CH_N-1:0][CNT_W-1:0]  cnt;
		logic [CNT_W-1:0]            capture;
		logic [9:0]                  div;
		logic                        dma_req;
		logic [CH_N-1:0]             unf_irq;
		logic                        cap_irq;
		logic                        ext_timer_clock_pin_o;
	} tcc_state_s;

	tcc_state_s      q;
	tcc_state_s      n;
	logic [CH_N-1:0] uf_evt;
	logic            cap_evt;
	logic            wr_go;

	tcc_edge_if ext_timer_clock_pin_e ();
	tcc_edge_if rtc_e ();

	tcc_pin_sync u_ext_timer_clock_pin_sync (
		.clk  (aclk),
		.rstn (aresetn),
		.pin  (ext_timer_clock_pin_i),
		.e    (ext_timer_clock_pin_e)
	);

	tcc_pin_sync u_rtc_sync (
		.clk  (aclk),
		.rstn (aresetn),
		.pin  (rtc_clk_i),
		.e    (rtc_e)
	);

	function automatic logic [15:0] ctl_mask(input int ch);
		if (ch == 2) begin
			return MASK_CH2;
		end else if (ch >= 3) begin
			return MASK_CH34;
		end
		return MASK_CH01;
	endfunction : ctl_mask

	function automatic logic edge_hit(input logic [1:0] e, input logic r, input logic f);
		if (e[1]) begin
			return r | f;
		end
		return e[0] ? f : r;
	endfunction : edge_hit

	// Channels 3 and 4 never tick on RTC, external or reserved codes.
	function automatic logic psc_tick(input logic [2:0] sel, input logic [9:0] dv,
			input logic rtc, input logic ext, input int ch);
		unique case (sel)
			PSC_DIV4:    return (dv & DMASK_4) == DMASK_4;
			PSC_DIV16:   return (dv & DMASK_16) == DMASK_16;
			PSC_DIV64:   return (dv & DMASK_64) == DMASK_64;
			PSC_DIV256:  return (dv & DMASK_256) == DMASK_256;
			PSC_DIV1024: return (dv & DMASK_1024) == DMASK_1024;
			PSC_RTC:     return (ch < 3) && rtc;
			PSC_EXT:     return (ch < 3) && ext;
			default:     return 1'b0;
		endcase
	endfunction : psc_tick

	function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] d,
			input logic [3:0] s);
		logic [31:0] m;
		m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		return (old & ~m) | (d & m);
	endfunction : lane_merge

	always_comb begin
		logic [31:0] rd;
		logic        ok;
		logic        tick;
		logic [15:0] wm;
		logic [2:0]  sel;
		rd      = 32'h00000000;
		ok      = 1'b0;
		tick    = 1'b0;
		wm      = 16'h0000;
		sel     = 3'h0;
		n       = q;
		uf_evt  = '0;
		cap_evt = 1'b0;
		wr_go   = q.aw_have & q.w_have & ~q.bvalid;
		n.div   = q.div + 10'h001;
		n.ext_timer_clock_pin_o = rtc_e.level;

		// Counting first, so that a software write to a counter overrides it.
		for (int i = 0; i < CH_N; i++) begin
			sel  = q.ctl[i][B_PSCHI:0];
			tick = q.start[i] & psc_tick(sel, q.div, rtc_e.rise,
				edge_hit(q.ctl[i][B_EDGEHI:B_EDGELO], ext_timer_clock_pin_e.rise, ext_timer_clock_pin_e.fall), i);
			// Gated clocks halt in standby; the RTC source keeps running.
			tick = tick & (~module_standby | (sel == PSC_RTC));
			if (tick) begin
				if (q.cnt[i] == '0) begin
					uf_evt[i] = 1'b1;
					n.cnt[i]  = q.reload[i];
				end else begin
					n.cnt[i] = q.cnt[i] - CNT_W'(1);
				end
			end
		end

		// Code 01 has bit 7 clear, so the reserved setting leaves capture off.
		cap_evt = q.ctl[2][B_CAPHI] & ~module_standby &
			edge_hit(q.ctl[2][B_EDGEHI:B_EDGELO], ext_timer_clock_pin_e.rise, ext_timer_clock_pin_e.fall);
		if (cap_evt && !q.ctl[2][B_CAPF]) begin
			n.capture = q.cnt[2];
		end
		if (dma_ack) begin
			n.dma_req = 1'b0;
		end
		if (cap_evt && !q.dma_req) begin
			n.dma_req = 1'b1;
		end

		if (awvalid && q.awready) begin
			n.aw_have = 1'b1;
			n.awready = 1'b0;
			n.waddr   = awaddr;
		end
		if (wvalid && q.wready) begin
			n.w_have = 1'b1;
			n.wready = 1'b0;
			n.wdat   = wdata;
			n.wstb   = wstrb;
		end
		if (q.bvalid && bready) begin
			n.bvalid  = 1'b0;
			n.awready = 1'b1;
			n.wready  = 1'b1;
		end
		if (wr_go) begin
			n.aw_have = 1'b0;
			n.w_have  = 1'b0;
			n.bvalid  = 1'b1;
			ok        = 1'b0;
			if (q.waddr == OFF_START) begin
				ok = 1'b1;
				if (q.wstb[0]) begin
					n.start = q.wdat[CH_N-1:0];
				end
			end
			if (q.waddr == OFF_OUTCTL) begin
				ok = 1'b1;
				if (q.wstb[0]) begin
					n.pin_oe = q.wdat[0];
				end
			end
			for (int i = 0; i < CH_N; i++) begin
				if (q.waddr == OFF_CTL + 8'(4 * i)) begin
					ok = 1'b1;
					wm = ctl_mask(i) & {{8{q.wstb[1]}}, {8{q.wstb[0]}}};
					wm[B_UNF]  = 1'b0;
					wm[B_CAPF] = 1'b0;
					n.ctl[i] = (q.ctl[i] & ~wm) | (q.wdat[15:0] & wm);
					// A written one leaves the flags untouched.
					if (q.wstb[1] && !q.wdat[B_UNF]) begin
						n.ctl[i][B_UNF] = 1'b0;
					end
					if (i == 2 && q.wstb[1] && !q.wdat[B_CAPF]) begin
						n.ctl[i][B_CAPF] = 1'b0;
					end
				end
				if (q.waddr == OFF_RELOAD + 8'(4 * i)) begin
					ok = 1'b1;
					n.reload[i] = CNT_W'(lane_merge(32'(q.reload[i]), q.wdat, q.wstb));
				end
				if (q.waddr == OFF_COUNT + 8'(4 * i)) begin
					ok = 1'b1;
					n.cnt[i] = CNT_W'(lane_merge(32'(q.cnt[i]), q.wdat, q.wstb));
				end
			end
			if (q.waddr == OFF_CAPTURE) begin
				ok = 1'b1;
			end
			n.bresp = ok ? RESP_OKAY : RESP_SLVERR;
		end

		// Hardware sets after the software clear, so a same-cycle event wins.
		for (int i = 0; i < CH_N; i++) begin
			if (uf_evt[i]) begin
				n.ctl[i][B_UNF] = 1'b1;
			end
		end
		if (cap_evt) begin
			n.ctl[2][B_CAPF] = 1'b1;
		end

		if (q.rvalid && rready) begin
			n.rvalid  = 1'b0;
			n.arready = 1'b1;
		end
		if (arvalid && q.arready) begin
			ok = 1'b0;
			rd = 32'h00000000;
			if (araddr == OFF_START) begin
				ok = 1'b1;
				rd = 32'(q.start);
			end
			if (araddr == OFF_OUTCTL) begin
				ok = 1'b1;
				rd = 32'(q.pin_oe);
			end
			for (int i = 0; i < CH_N; i++) begin
				if (araddr == OFF_CTL + 8'(4 * i)) begin
					ok = 1'b1;
					rd = 32'(q.ctl[i] & ctl_mask(i));
				end
				if (araddr == OFF_RELOAD + 8'(4 * i)) begin
					ok = 1'b1;
					rd = 32'(q.reload[i]);
				end
				if (araddr == OFF_COUNT + 8'(4 * i)) begin
					ok = 1'b1;
					rd = 32'(q.cnt[i]);
				end
			end
			if (araddr == OFF_CAPTURE) begin
				ok = 1'b1;
				rd = 32'(q.capture);
			end
			n.rvalid  = 1'b1;
			n.arready = 1'b0;
			n.rdata   = rd;
			n.rresp   = ok ? RESP_OKAY : RESP_SLVERR;
		end

		for (int i = 0; i < CH_N; i++) begin
			n.unf_irq[i] = n.ctl[i][B_UNF] & n.ctl[i][B_UNDERFLOW_IRQ_ENABLE];
		end
		n.cap_irq = n.ctl[2][B_CAPF] & n.ctl[2][B_CAPHI] & n.ctl[2][B_CAPLO];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q         <= '0;
			q.awready <= 1'b1;
			q.wready  <= 1'b1;
			q.arready <= 1'b1;
			q.start   <= START_RST;
			q.ctl     <= {CH_N{CTL_RST}};
			q.reload  <= {CH_N{CNT_W'(RELOAD_RST)}};
			q.cnt     <= {CH_N{CNT_W'(COUNT_RST)}};
		end else begin
			q <= n;
		end
	end

	assign awready       = q.awready;
	assign wready        = q.wready;
	assign bvalid        = q.bvalid;
	assign bresp         = q.bresp;
	assign arready       = q.arready;
	assign rvalid        = q.rvalid;
	assign rresp         = q.rresp;
	assign rdata         = q.rdata;
	assign ext_timer_clock_pin_o        = q.ext_timer_clock_pin_o;
	assign ext_timer_clock_pin_oe       = q.pin_oe;
	assign dma_req       = q.dma_req;
	assign underflow_irq = q.unf_irq;
	assign capture_irq   = q.cap_irq;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	reserved_zero_a: assert property (((q.ctl[0] | q.ctl[1]) & ~MASK_CH01) == '0)
		else $error("reserved control bits hold a one");
	narrow_ctl_a: assert property (((q.ctl[3] | q.ctl[4]) & ~MASK_CH34) == '0)
		else $error("channel 3 or 4 holds an unimplemented bit");
	cap_flag_set_a: assert property (cap_evt |=> q.ctl[2][B_CAPF])
		else $error("capture flag not set after capture");
	unf_set_a: assert property (uf_evt[0] |=> q.ctl[0][B_UNF] ##1 (q.ctl[0][B_UNF] || $past(wr_go)))
		else $error("underflow flag lost without a write");
	flag_keep_a: assert property (q.ctl[1][B_UNF] && !(wr_go && q.wstb[1] && !q.wdat[B_UNF] &&
		q.waddr == OFF_CTL + 8'h04) |=> q.ctl[1][B_UNF])
		else $error("underflow flag cleared without a zero write");
	dma_raise_a: assert property (cap_evt && !dma_req |=> dma_req)
		else $error("capture did not raise a transfer request");
	cap_hold_a: assert property (cap_evt && q.ctl[2][B_CAPF] |=> $stable(q.capture))
		else $error("capture register overwritten while flag set");
	dma_hold_a: assert property (dma_req && !dma_ack |=> dma_req)
		else $error("transfer request dropped before acknowledge");
	cap_irq_a: assert property (capture_irq == (q.ctl[2][B_CAPF] && q.ctl[2][7:6] == 2'h3))
		else $error("capture interrupt disagrees with flag and enable");
	unf_irq_a: assert property (underflow_irq[4] == (q.ctl[4][B_UNF] & q.ctl[4][B_UNDERFLOW_IRQ_ENABLE]))
		else $error("underflow interrupt disagrees with flag and enable");
	reload_a: assert property (uf_evt[0] && !wr_go |=> q.cnt[0] == $past(q.reload[0]))
		else $error("counter not reloaded on underflow");
	standby_a: assert property (module_standby && q.ctl[0][2:0] != PSC_RTC && !wr_go
		|=> $stable(q.cnt[0]))
		else $error("gated channel counted in standby");
endmodule : tcc_timer

// >>> tcc_timer_test.sv
// Self-checking bench for the five-channel timer control block.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("Error %s expected %0h seen %0h", nm, e, g); end end
module tcc_timer_test
	import tcc_pkg::*;
;
	logic        aclk = 1'b0, aresetn = 1'b0, standby = 1'b0, pin_q = 1'b0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00, ack_dly = 8'd2;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'hf;
	logic        awready, wready, bvalid, arready, rvalid, ext_timer_clock_pin_o, ext_timer_clock_pin_oe, dma_req;
	logic        capture_irq, pin_w;
	logic [3:0]  rtc_div = 4'h0;
	logic [1:0]  bresp, rresp, last_rsp;
	logic [31:0] rdata;
	logic [4:0]  underflow_irq;
	wire logic   dma_ack;
	int          n_req, n_errors = 0, n_checks = 0, cyc = 0;

	// The pin is only ours while the block leaves it undriven.
	assign pin_w = ext_timer_clock_pin_oe ? ext_timer_clock_pin_o : pin_q;

	always #5 aclk = ~aclk;

	// Slow stand-in for the real-time clock, one rise every 16 cycles.
	always @(posedge aclk) begin
		rtc_div <= rtc_div + 4'h1;
	end

	tcc_timer #(.CNT_W(32)) dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .ext_timer_clock_pin_i(pin_w), .ext_timer_clock_pin_o(ext_timer_clock_pin_o), .ext_timer_clock_pin_oe(ext_timer_clock_pin_oe),
		.rtc_clk_i(rtc_div[3]), .module_standby(standby), .dma_req(dma_req), .dma_ack(dma_ack),
		.underflow_irq(underflow_irq), .capture_irq(capture_irq));

	tcc_dma_model dma_u (.aclk(aclk), .aresetn(aresetn), .dma_req(dma_req),
		.ack_delay(ack_dly), .dma_ack(dma_ack), .n_req(n_req));

	task automatic print_verdict;
		$display("Checks %0d, errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict

	function automatic logic [7:0] ra(input logic [7:0] b, input int c);
		return b + 8'(4 * c);
	endfunction : ra

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			t++;
		end while (bvalid !== 1'b1 && t < 50);
		last_rsp = bresp;
		bready <= 1'b0;
		if (t >= 50)
			n_errors++;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
		int t;
		t = 0;
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
			t++;
		end while (rvalid !== 1'b1 && t < 50);
		d = rdata;
		last_rsp = rresp;
		rready <= 1'b0;
		if (t >= 50)
			n_errors++;
	endtask : axi_rd

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
		logic [31:0] d;
		axi_rd(a, d);
		`CHK(nm, e, d)
	endtask : rd_chk

	task automatic pin(input logic v);
		@(posedge aclk);
		pin_q <= v;
		repeat (12) @(posedge aclk);
	endtask : pin

	task automatic t_regs;
		logic [31:0] d;
		for (int i = 0; i < CH_N; i++) begin
			rd_chk(ra(OFF_CTL, i), 32'h0, "ctl reset");
			axi_wr(ra(OFF_CTL, i), 32'hffffffff);
			d = (i == 2) ? 32'hff : ((i > 2) ? 32'h27 : 32'h3f);
			rd_chk(ra(OFF_CTL, i), d, "ctl mask");
			axi_wr(ra(OFF_CTL, i), 32'h0);
		end
		axi_rd(8'hfc, d);
		`CHK("unmapped resp", RESP_SLVERR, last_rsp)
		`CHK("unmapped data", 32'h0, d)
		axi_wr(8'hfc, 32'hffffffff);
		`CHK("unmapped wresp", RESP_SLVERR, last_rsp)
	endtask : t_regs

	task automatic t_unf;
		logic [31:0] d;
		int          t;
		int          chs[3] = '{0, 1, 4};
		foreach (chs[k]) begin
			axi_wr(ra(OFF_RELOAD, chs[k]), 32'h10);
			axi_wr(ra(OFF_COUNT, chs[k]), 32'h2);
			axi_wr(ra(OFF_CTL, chs[k]), (k == 1) ? 32'h0 : 32'h20);
		end
		axi_wr(OFF_START, 32'h13);
		t = 0;
		while (underflow_irq !== 5'h11 && t < 200) begin
			@(posedge aclk);
			t++;
		end
		axi_wr(OFF_START, 32'h0);
		`CHK("unf irq", 5'h11, underflow_irq)
		rd_chk(OFF_CTL, 32'h120, "unf ch0");
		rd_chk(ra(OFF_CTL, 1), 32'h100, "unf ch1");
		axi_rd(OFF_COUNT, d);
		`CHK("reload", 27'h0, d[31:5])
		axi_wr(OFF_CTL, 32'h120);
		rd_chk(OFF_CTL, 32'h120, "flag keep");
		axi_wr(OFF_CTL, 32'h20);
		rd_chk(OFF_CTL, 32'h20, "flag clear");
		`CHK("irq off", 5'h10, underflow_irq)
	endtask : t_unf

	task automatic t_psc;
		int n;
		int p;
		for (int c = 0; c < 5; c++) begin
			p = 4 << (2 * c);
			axi_wr(OFF_START, 32'h0);
			axi_wr(OFF_CTL, 32'h20 | 32'(c));
			axi_wr(OFF_COUNT, 32'h1);
			axi_wr(OFF_START, 32'h1);
			n = 0;
			while (underflow_irq[0] !== 1'b1 && n < 3000) begin
				@(posedge aclk);
				n++;
			end
			`CHK("psc early", 1'b1, n >= p - 8)
			`CHK("psc late", 1'b1, n <= 2 * p + 16)
		end
		axi_wr(OFF_START, 32'h0);
		axi_wr(OFF_CTL, 32'h0);
		axi_wr(OFF_COUNT, 32'h100);
		standby <= 1'b1;
		axi_wr(OFF_START, 32'h1);
		repeat (40) @(posedge aclk);
		rd_chk(OFF_COUNT, 32'h100, "standby hold");
		standby <= 1'b0;
		axi_wr(OFF_START, 32'h0);
	endtask : t_psc

	task automatic t_src;
		logic [31:0] d;
		logic        s0;
		logic        s1;
		s0 = 1'b0;
		s1 = 1'b0;
		axi_wr(OFF_CTL, 32'h07);
		axi_wr(OFF_COUNT, 32'h10);
		axi_wr(OFF_START, 32'h1);
		pin(1'b1);
		pin(1'b0);
		pin(1'b1);
		rd_chk(OFF_COUNT, 32'he, "ext rise");
		axi_wr(OFF_CTL, 32'h17);
		pin(1'b0);
		rd_chk(OFF_COUNT, 32'hd, "ext both");
		axi_wr(OFF_START, 32'h0);
		axi_wr(ra(OFF_CTL, 1), 32'h06);
		axi_wr(ra(OFF_COUNT, 1), 32'h100);
		standby <= 1'b1;
		axi_wr(OFF_START, 32'h2);
		repeat (80) @(posedge aclk);
		axi_rd(ra(OFF_COUNT, 1), d);
		standby <= 1'b0;
		`CHK("rtc standby", 1'b1, d < 32'h100 && d > 32'hf8)
		axi_wr(OFF_START, 32'h0);
		axi_wr(OFF_OUTCTL, 32'h1);
		`CHK("pin oe on", 1'b1, ext_timer_clock_pin_oe)
		repeat (40) begin
			@(posedge aclk);
			s0 = s0 | ~ext_timer_clock_pin_o;
			s1 = s1 | ext_timer_clock_pin_o;
		end
		`CHK("pin drive", 2'h3, {s1, s0})
		axi_wr(OFF_OUTCTL, 32'h0);
		`CHK("pin oe off", 1'b0, ext_timer_clock_pin_oe)
	endtask : t_src

	task automatic t_cap;
		int b;
		b = n_req;
		// The pin must be an input before capture is used.
		axi_wr(OFF_OUTCTL, 32'h0);
		axi_wr(ra(OFF_CTL, 2), 32'h0);
		axi_wr(ra(OFF_COUNT, 2), 32'h1234);
		pin(1'b1);
		pin(1'b0);
		`CHK("dma off", b, n_req)
		axi_wr(ra(OFF_CTL, 2), 32'h40);
		pin(1'b1);
		pin(1'b0);
		`CHK("dma reserved", b, n_req)
		axi_wr(ra(OFF_CTL, 2), 32'hc0);
		pin(1'b1);
		rd_chk(ra(OFF_CTL, 2), 32'h2c0, "cap flag");
		rd_chk(OFF_CAPTURE, 32'h1234, "cap value");
		`CHK("cap irq", 1'b1, capture_irq)
		`CHK("dma one", b + 1, n_req)
		axi_wr(ra(OFF_COUNT, 2), 32'h5678);
		pin(1'b0);
		pin(1'b1);
		rd_chk(OFF_CAPTURE, 32'h1234, "cap kept");
		`CHK("dma again", b + 2, n_req)
		axi_wr(ra(OFF_CTL, 2), 32'hc0);
		rd_chk(ra(OFF_CTL, 2), 32'hc0, "cap clear");
		`CHK("cap irq off", 1'b0, capture_irq)
		axi_wr(ra(OFF_CTL, 2), 32'h88);
		pin(1'b0);
		rd_chk(ra(OFF_CTL, 2), 32'h288, "fall edge");
		rd_chk(OFF_CAPTURE, 32'h5678, "cap fall");
		`CHK("mode10 irq", 1'b0, capture_irq)
		`CHK("dma three", b + 3, n_req)
		ack_dly <= 8'd60;
		axi_wr(ra(OFF_CTL, 2), 32'h90);
		pin(1'b1);
		`CHK("dma pending", 1'b1, dma_req)
		pin(1'b0);
		pin(1'b1);
		repeat (80) @(posedge aclk);
		`CHK("dma held", b + 4, n_req)
	endtask : t_cap

	// A hung handshake ends the run through the normal report.
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 30000) begin
			n_errors++;
			print_verdict();
		end
	end

	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_unf();
		t_psc();
		t_src();
		t_cap();
		print_verdict();
	end
endmodule : tcc_timer_test
